// File: test_usb_in_endpoint_control.sv
`timescale 1ns/10ps
`include "usbin_defs.vh"
module test_usb_in_endpoint_control;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, in_token, tx_end, tx_ack, load_strobe, resp_valid, resp_data1, er;
	logic [3:0] token_ep, load_ep;
	logic [1:0] resp_kind;
	logic [2:0] ep_irq, ep_dir_in, ep_iso;
	logic [7:0] cfg[0:3], om[0:3];
	integer n_mismatch = 0, checks = 0, seed = 33, irq_n = 0, xirq = 0, ep, le, mp, i;
	integer pk[0:3], tog[0:3], stl[0:3], sent[0:3], und[0:3];
	usbin_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.in_token(in_token), .token_ep(token_ep), .tx_end(tx_end), .tx_ack(tx_ack),
		.load_strobe(load_strobe), .load_ep(load_ep), .resp_valid(resp_valid), .resp_kind(resp_kind),
		.resp_data1(resp_data1), .ep_irq(ep_irq), .ep_dir_in(ep_dir_in), .ep_iso(ep_iso));
	uie_host u_host (.pclk(pclk), .in_token(in_token), .token_ep(token_ep), .tx_end(tx_end),
		.tx_ack(tx_ack), .load_strobe(load_strobe), .load_ep(load_ep));
	// Bus clock, 8 ns period.
	initial begin
		forever #4 pclk = ~pclk;
	end
	// Interrupt pulses are tallied so that no single cycle has to be hit.
	always @(posedge pclk) begin
		irq_n <= irq_n + ep_irq[0] + ep_irq[1] + ep_irq[2];
	end
	// A hang ends the run as a failure.
	initial begin
		#160000;
		n_mismatch = n_mismatch + 1;
		close_out;
	end
	////////////////////////////////////////////////////////////////
	task close_out;
		begin
			if (n_mismatch == 0 && checks > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input logic [35:0] s, input logic [35:0] x);
		begin
			checks = checks + 1;
			if (s !== x) begin
				n_mismatch = n_mismatch + 1;
				$display("unexpected at %0t: seen %h expected %h", $time, s, x);
			end
		end
	endtask
	// Request is held until ready is sampled high at a rising edge.
	task apb(input logic w, input logic [5:0] idx, input logic [7:0] d);
		integer n;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= {idx, 2'b00};
			pwdata <= {24'h000000, d};
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			@(posedge pclk);
			while (pready !== 1'b1 && n < 16) begin
				@(posedge pclk);
				n = n + 1;
			end
			// A bus that never answers counts as a mismatch.
			if (n >= 16)
				n_mismatch = n_mismatch + 1;
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rd_chk(input logic [5:0] idx, input logic [7:0] x);
		begin
			apb(1'b0, idx, 8'h00);
			chk({er, rd}, {1'b0, 24'h0, x});
		end
	endtask
	task sel(input integer e);
		begin
			apb(1'b1, 6'h0e, e[7:0]);
			ep = e;
		end
	endtask
	// Status read; the two sticky flags clear once read.
	task rdcsr;
		begin
			apb(1'b0, 6'h11, 8'h00);
			chk(rd, {sent[ep][0], stl[ep][0], 1'b0, und[ep][0], pk[ep] != 0, pk[ep] != 0});
			chk(irq_n, xirq);
			chk({ep_iso, ep_dir_in}, {cfg[3][6], cfg[2][6], cfg[1][6], cfg[3][5], cfg[2][5], cfg[1][5]});
			sent[ep] = 0;
			und[ep] = 0;
		end
	endtask
	task cw(input logic [7:0] v);
		begin
			apb(1'b1, 6'h11, v);
			if (v[6])
				tog[ep] = 0;
			stl[ep] = v[4];
			if (v[3] && pk[ep] != 0) begin
				pk[ep] = pk[ep] - 1;
				xirq = xirq + (pk[ep] == 0);
			end
			if (v[0] && pk[ep] < 2)
				pk[ep] = pk[ep] + 1;
		end
	endtask
	task cfgw(input logic [7:0] v);
		begin
			apb(1'b1, 6'h12, v);
			cfg[ep] = v;
			rd_chk(6'h12, v);
		end
	endtask
	// Expected answer is worked out before the token goes out.
	task tok(input integer e);
		logic [1:0] k;
		begin
			le = e;
			k = `USBIN_RESP_NAK;
			if (e >= 1 && e <= 3) begin
				if (stl[e] != 0 && !cfg[e][6]) begin
					k = `USBIN_RESP_STALL;
					xirq = xirq + (pk[e] != 0);
					pk[e] = 0;
					sent[e] = 1;
				end else if (pk[e] != 0) begin
					k = `USBIN_RESP_DATA;
				end else begin
					k = cfg[e][6] ? `USBIN_RESP_ZLP : `USBIN_RESP_NAK;
					und[e] = 1;
				end
			end
			u_host.token(e[3:0]);
			@(negedge pclk);
			chk({resp_valid, resp_kind, resp_data1 & (k == 2'h1)}, {1'b1, k, tog[le][0] & (k == 2'h1)});
		end
	endtask
	task send(input logic a);
		begin
			u_host.finish(a);
			if (cfg[le][6] || cfg[le][3] || a) begin
				if (!cfg[le][6])
					tog[le] = 1 - tog[le];
				pk[le] = pk[le] - 1;
				xirq = xirq + (pk[le] == 0);
			end
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		for (i = 0; i < 4; i = i + 1) begin
			pk[i] = 0;
			tog[i] = 0;
			stl[i] = 0;
			sent[i] = 0;
			und[i] = 0;
			cfg[i] = 8'h00;
		end
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 6'h18, 8'h0e);
		for (i = 1; i < 4; i = i + 1) begin
			sel(i);
			rdcsr;
			rd_chk(6'h12, 8'h00);
			rd_chk(6'h10, 8'h00);
			rd_chk(6'h13, 8'h00);
			om[i] = $random(seed);
			apb(1'b1, 6'h13, om[i]);
		end
		for (i = 1; i < 4; i = i + 1) begin
			sel(i);
			rd_chk(6'h13, om[i]);
		end
		apb(1'b0, 6'h1f, 8'h00);
		chk({er, rd}, {1'b1, 32'h0});
		sel(1 + $unsigned($random(seed)) % 3);
		cw(8'h01);
		rdcsr;
		tok(ep);
		send(1'b1);
		cw(8'h40);
		cw(8'h01);
		tok(ep);
		send(1'b0);
		tok(ep);
		send(1'b1);
		cw(8'h01);
		tok(ep);
		send(1'b1);
		tok(0);
		tok(15);
		tok(ep);
		rdcsr;
		rdcsr;
		cw(8'h11);
		tok(ep);
		tok(ep);
		rdcsr;
		rdcsr;
		cw(8'h00);
		tok(ep);
		rdcsr;
		cw(8'h01);
		cw(8'h08);
		rdcsr;
		cfgw(8'h08);
		cw(8'h01);
		tok(ep);
		send(1'b0);
		rdcsr;
		cfgw(8'h60);
		cw(8'h10);
		tok(ep);
		rdcsr;
		cw(8'h11);
		tok(ep);
		send(1'b0);
		rdcsr;
		cw(8'h00);
		// Auto-arm needs exactly limit times eight bytes; the limit stays below 8 units.
		mp = 1 + $unsigned($random(seed)) % 7;
		apb(1'b1, 6'h10, mp[7:0]);
		rd_chk(6'h10, mp[7:0]);
		cfgw(8'h80);
		for (i = 1; i < mp * 8; i = i + 1)
			u_host.load(ep[3:0]);
		rdcsr;
		u_host.load(ep[3:0]);
		pk[ep] = 1;
		rdcsr;
		cw(8'h08);
		rdcsr;
		// Two queued packets need two flush requests before the buffer is empty.
		cw(8'h01);
		cw(8'h01);
		cw(8'h08);
		cw(8'h08);
		rdcsr;
		close_out;
	end
endmodule

// File: uie_ctrl_chk.sv
`timescale 1ns/10ps
`include "usbin_defs.vh"
module uie_ctrl_chk (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pready,
	input logic pslverr,
	input logic [31:0] prdata,
	input logic in_token,
	input logic [3:0] token_ep,
	input logic resp_valid,
	input logic [1:0] resp_kind,
	input logic [2:0] ep_iso,
	input logic [2:0] ep_irq
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// The bus never waits, so a missing ready would hang software.
	setup_gets_ready_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_single_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	err_with_ready_a: assert property (pslverr |-> pready)
		else $error("error without ready");
	idle_data_zero_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	token_answered_a: assert property (in_token |=> resp_valid)
		else $error("token not answered");
	answer_has_cause_a: assert property (resp_valid |-> $past(in_token))
		else $error("answer without token");
	bad_ep_nak_a: assert property (in_token && (token_ep == 4'h0 || token_ep > 4'h3)
		|=> resp_kind == `USBIN_RESP_NAK) else $error("absent endpoint not refused");
	iso_no_stall_a: assert property (in_token && token_ep inside {4'h1, 4'h2, 4'h3}
		&& ep_iso[token_ep[1:0] - 2'd1] |=> resp_kind != `USBIN_RESP_STALL) else $error("stall in iso");
	// Main scenarios reached.
	cover property (resp_valid && resp_kind == `USBIN_RESP_STALL);
	cover property (resp_valid && resp_kind == `USBIN_RESP_ZLP);
	cover property (ep_irq != 3'h0);
endmodule
bind usbin_ctrl uie_ctrl_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .prdata(prdata), .in_token(in_token), .token_ep(token_ep),
	.resp_valid(resp_valid), .resp_kind(resp_kind), .ep_iso(ep_iso), .ep_irq(ep_irq));

// File: uie_host.sv
`timescale 1ns/10ps
// Packet engine stand-in; pulses last one cycle and idle lines show inverted values.
module uie_host (
	input wire pclk,
	output reg in_token,
	output reg [3:0] token_ep,
	output reg tx_end,
	output reg tx_ack,
	output reg load_strobe,
	output reg [3:0] load_ep
);
	// Quiet lines at time zero.
	initial begin
		in_token = 1'b0;
		token_ep = 4'h0;
		tx_end = 1'b0;
		tx_ack = 1'b0;
		load_strobe = 1'b0;
		load_ep = 4'h0;
	end
	// One IN token towards endpoint e.
	task token(input logic [3:0] e);
		begin
			@(posedge pclk);
			in_token <= 1'b1;
			token_ep <= e;
			@(posedge pclk);
			in_token <= 1'b0;
			token_ep <= ~e;
		end
	endtask
	// End of a data packet; a says whether the host handshake came back.
	task finish(input logic a);
		begin
			@(posedge pclk);
			tx_end <= 1'b1;
			tx_ack <= a;
			@(posedge pclk);
			tx_end <= 1'b0;
			tx_ack <= ~a;
		end
	endtask
	// One byte into the IN buffer of endpoint e.
	task load(input logic [3:0] e);
		begin
			@(posedge pclk);
			load_strobe <= 1'b1;
			load_ep <= e;
			@(posedge pclk);
			load_strobe <= 1'b0;
			load_ep <= ~e;
		end
	endtask
endmodule

// File: usbin_ctrl.v
`timescale 1ns/10ps
`include "usbin_defs.vh"
module usbin_ctrl (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire in_token,
	input wire [3:0] token_ep,
	input wire tx_end,
	input wire tx_ack,
	input wire load_strobe,
	input wire [3:0] load_ep,
	output reg resp_valid,
	output reg [1:0] resp_kind,
	output reg resp_data1,
	output reg [2:0] ep_irq,
	output reg [2:0] ep_dir_in,
	output reg [2:0] ep_iso
);
	reg [3:0] ep_sel_reg;
	reg [2:0] irq_en_reg;
	reg [3:0] cur_ep_reg;
	reg [31:0] rdata_next;
	reg slverr_next;
	wire [5:0] idx;
	wire setup;
	wire access_done;
	wire wr_done;
	wire rd_done;
	wire sel_ok;
	wire [2:0] ep_is_sel;
	wire [2:0] ep_tok;
	wire [2:0] ep_end;
	wire [2:0] ep_load;
	wire [2:0] ep_done;
	wire [7:0] csr_rd [0:2];
	wire [7:0] cfg_rd [0:2];
	wire [7:0] maxp_rd [0:2];
	wire [7:0] out_max_packet_size_rd [0:2];
	wire [1:0] kind [0:2];
	wire [2:0] data1;
	reg [7:0] sel_csr;
	reg [7:0] sel_cfg;
	reg [7:0] sel_maxp;
	reg [7:0] sel_out_max_packet_size;
	reg [1:0] tok_kind;
	reg tok_data1;
	integer i;

	////////////////////////////////////////////////////////////////////////////
	// APB decode. Registers sit one per word, so the index is paddr[7:2].
	assign idx = paddr[7:2];
	assign setup = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_done = access_done & pwrite & ~pslverr;
	assign rd_done = access_done & ~pwrite & ~pslverr;
	// Only endpoints 1 to 3 own a set; others show an empty window.
	assign sel_ok = (ep_sel_reg != 4'h0) & (ep_sel_reg <= 4'h3);

	////////////////////////////////////////////////////////////////////////////
	// One register set per IN endpoint.
	genvar g;
	generate
		for (g = 0; g < `USBIN_NUM_EP; g = g + 1) begin : gen_ep
			assign ep_is_sel[g] = (ep_sel_reg == g + 1);
			assign ep_tok[g] = in_token & (token_ep == g + 1);
			assign ep_end[g] = tx_end & (cur_ep_reg == g + 1);
			assign ep_load[g] = load_strobe & (load_ep == g + 1);
			usbin_ep_slot u_slot (
				.pclk(pclk),
				.presetn(presetn),
				.wr_csr(wr_done & ep_is_sel[g] & (idx == `USBIN_IDX_IN_CSR)),
				.wr_cfg(wr_done & ep_is_sel[g] & (idx == `USBIN_IDX_IN_CFG)),
				.wr_maxp(wr_done & ep_is_sel[g] & (idx == `USBIN_IDX_IN_MAXP)),
				.wr_out_max_packet_size(wr_done & ep_is_sel[g] & (idx == `USBIN_IDX_OUT_MAXP)),
				.rd_csr(rd_done & ep_is_sel[g] & (idx == `USBIN_IDX_IN_CSR)),
				.wdata(pwdata[7:0]),
				.token(ep_tok[g]),
				.tx_end(ep_end[g]),
				.tx_ack(tx_ack),
				.load(ep_load[g]),
				.csr_rd(csr_rd[g]),
				.cfg_rd(cfg_rd[g]),
				.maxp_rd(maxp_rd[g]),
				.out_max_packet_size_rd(out_max_packet_size_rd[g]),
				.resp_kind(kind[g]),
				.data1(data1[g]),
				.done_evt(ep_done[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Multiplex the selected set and the token's endpoint.
	always @* begin
		sel_csr = 8'h00;
		sel_cfg = 8'h00;
		sel_maxp = 8'h00;
		sel_out_max_packet_size = 8'h00;
		tok_kind = `USBIN_RESP_NAK;
		tok_data1 = 1'b0;
		for (i = 0; i < `USBIN_NUM_EP; i = i + 1) begin
			if (ep_is_sel[i]) begin
				sel_csr = csr_rd[i];
				sel_cfg = cfg_rd[i];
				sel_maxp = maxp_rd[i];
				sel_out_max_packet_size = out_max_packet_size_rd[i];
			end
			if (ep_tok[i]) begin
				tok_kind = kind[i];
				tok_data1 = data1[i];
			end
		end
	end

	// Read data and error answer, captured in the setup cycle.
	always @* begin
		rdata_next = 32'h00000000;
		slverr_next = 1'b0;
		case (idx)
			`USBIN_IDX_EP_SELECT: begin
				rdata_next = {28'h0000000, ep_sel_reg};
			end
			`USBIN_IDX_IN_MAXP: begin
				rdata_next = {24'h000000, sel_maxp};
			end
			`USBIN_IDX_IN_CSR: begin
				rdata_next = {24'h000000, sel_csr};
			end
			`USBIN_IDX_IN_CFG: begin
				rdata_next = {24'h000000, sel_cfg};
			end
			`USBIN_IDX_OUT_MAXP: begin
				rdata_next = {24'h000000, sel_out_max_packet_size};
			end
			`USBIN_IDX_IRQ_EN: begin
				rdata_next = {28'h0000000, irq_en_reg, 1'b0};
			end
			default: begin
				slverr_next = 1'b1;
			end
		endcase
	end

	// Exactly one wait-free access phase: pready rises for the cycle after setup.
	// Clear-on-read flags are captured at setup but cleared only at completion.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (setup) begin
			prdata <= pwrite ? 32'h00000000 : rdata_next;
			pready <= 1'b1;
			pslverr <= slverr_next;
		end else begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Block-level registers: endpoint select and interrupt enables.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ep_sel_reg <= 4'h0;
			irq_en_reg <= 3'h0;
		end else if (wr_done) begin
			if (idx == `USBIN_IDX_EP_SELECT) begin
				ep_sel_reg <= pwdata[3:0];
			end
			if (idx == `USBIN_IDX_IRQ_EN) begin
				irq_en_reg <= pwdata[3:1];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Token answer, one cycle after the token. The endpoint is kept so that
	// the end-of-send report reaches the right set.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			resp_valid <= 1'b0;
			resp_kind <= `USBIN_RESP_NAK;
			resp_data1 <= 1'b0;
			cur_ep_reg <= 4'h0;
		end else begin
			resp_valid <= in_token;
			if (in_token) begin
				resp_kind <= tok_kind;
				resp_data1 <= tok_data1;
				cur_ep_reg <= token_ep;
			end
		end
	end

	// Interrupt pulse when an endpoint's armed bit is cleared.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ep_irq <= 3'h0;
		end else begin
			ep_irq <= ep_done & irq_en_reg;
		end
	end

	// Mode bits shown to the packet engine.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ep_dir_in <= 3'h0;
			ep_iso <= 3'h0;
		end else begin
			for (i = 0; i < `USBIN_NUM_EP; i = i + 1) begin
				ep_dir_in[i] <= cfg_rd[i][`USBIN_CFG_DIR_IN];
				ep_iso[i] <= cfg_rd[i][`USBIN_CFG_ISO];
			end
		end
	end
endmodule

// File: usbin_defs.vh
`ifndef USBIN_DEFS_VH
`define USBIN_DEFS_VH
// Register indices; byte address is four times the index.
`define USBIN_IDX_EP_SELECT 6'h0e
`define USBIN_IDX_IN_MAXP 6'h10
`define USBIN_IDX_IN_CSR 6'h11
`define USBIN_IDX_IN_CFG 6'h12
`define USBIN_IDX_OUT_MAXP 6'h13
`define USBIN_IDX_IRQ_EN 6'h18
`define USBIN_RESET_VAL 8'h00
`define USBIN_NUM_EP 3
// in_endpoint_control_status fields.
`define USBIN_CSR_TOG_RESET 6
`define USBIN_CSR_STALL_SENT 5
`define USBIN_CSR_STALL_REQ 4
`define USBIN_CSR_DROP 3
`define USBIN_CSR_UNDERRUN 2
`define USBIN_CSR_OCCUPIED 1
`define USBIN_CSR_ARMED 0
// in_endpoint_config fields.
`define USBIN_CFG_AUTO_ARM 7
`define USBIN_CFG_ISO 6
`define USBIN_CFG_DIR_IN 5
`define USBIN_CFG_FORCE_FLIP 3
// Answers to an IN token.
`define USBIN_RESP_NAK 2'h0
`define USBIN_RESP_DATA 2'h1
`define USBIN_RESP_STALL 2'h2
`define USBIN_RESP_ZLP 2'h3
// Packets the IN FIFO can hold.
`define USBIN_MAX_PKTS 2'h2
`endif

// File: usbin_ep_slot.v
`timescale 1ns/10ps
`include "usbin_defs.vh"
module usbin_ep_slot (
	input wire pclk,
	input wire presetn,
	input wire wr_csr,
	input wire wr_cfg,
	input wire wr_maxp,
	input wire wr_out_max_packet_size,
	input wire rd_csr,
	input wire [7:0] wdata,
	input wire token,
	input wire tx_end,
	input wire tx_ack,
	input wire load,
	output wire [7:0] csr_rd,
	output wire [7:0] cfg_rd,
	output wire [7:0] maxp_rd,
	output wire [7:0] out_max_packet_size_rd,
	output reg [1:0] resp_kind,
	output wire data1,
	output wire done_evt
);
	reg toggle_reg;
	reg stall_sent_reg;
	reg stall_req_reg;
	reg underrun_reg;
	reg armed_reg;
	reg [1:0] pkts_reg;
	reg [10:0] bytes_reg;
	reg [7:0] cfg_reg;
	reg [7:0] maxp_reg;
	reg [7:0] out_max_packet_size_reg;
	wire iso;
	wire force_flip;
	wire stalling;
	wire full_load;
	wire sent_ok;
	wire flush;
	wire arm_now;

	////////////////////////////////////////////////////////////////////////////
	assign iso = cfg_reg[`USBIN_CFG_ISO];
	assign force_flip = cfg_reg[`USBIN_CFG_FORCE_FLIP];
	assign stalling = stall_req_reg & ~iso;
	// Auto-arm compares against the size in 8-byte units.
	assign full_load = load & cfg_reg[`USBIN_CFG_AUTO_ARM] & (maxp_reg != 8'h00) &
		((bytes_reg + 11'h001) == {maxp_reg, 3'b000});
	assign arm_now = (wr_csr & wdata[`USBIN_CSR_ARMED]) | full_load;
	assign flush = wr_csr & wdata[`USBIN_CSR_DROP];
	// Isochronous packets are never acknowledged, so they are done on send.
	assign sent_ok = tx_end & (tx_ack | force_flip | iso);
	assign done_evt = armed_reg & (sent_ok | flush | (token & stalling));
	assign data1 = toggle_reg;

	// Answer chosen for an IN token on this endpoint.
	always @* begin
		if (stalling) begin
			resp_kind = `USBIN_RESP_STALL;
		end else if (armed_reg | (pkts_reg != 2'h0)) begin
			resp_kind = `USBIN_RESP_DATA;
		end else if (iso) begin
			resp_kind = `USBIN_RESP_ZLP;
		end else begin
			resp_kind = `USBIN_RESP_NAK;
		end
	end

	// Flags: a hardware set wins over a clear-on-read in the same cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stall_sent_reg <= 1'b0;
			underrun_reg <= 1'b0;
			stall_req_reg <= 1'b0;
			toggle_reg <= 1'b0;
		end else begin
			if (token & stalling) begin
				stall_sent_reg <= 1'b1;
			end else if (rd_csr) begin
				stall_sent_reg <= 1'b0;
			end
			if (token & ~stalling & ~armed_reg & (pkts_reg == 2'h0)) begin
				underrun_reg <= 1'b1;
			end else if (rd_csr) begin
				underrun_reg <= 1'b0;
			end
			if (wr_csr) begin
				stall_req_reg <= wdata[`USBIN_CSR_STALL_REQ];
			end
			if (wr_csr & wdata[`USBIN_CSR_TOG_RESET]) begin
				toggle_reg <= 1'b0;
			end else if (tx_end & ~iso & (tx_ack | force_flip)) begin
				toggle_reg <= ~toggle_reg;
			end
		end
	end

	// Packet bookkeeping; a stall empties the whole FIFO, a flush drops one.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_reg <= 1'b0;
			pkts_reg <= 2'h0;
			bytes_reg <= 11'h000;
		end else if (token & stalling) begin
			armed_reg <= 1'b0;
			pkts_reg <= 2'h0;
			bytes_reg <= 11'h000;
		end else if (flush | sent_ok) begin
			armed_reg <= 1'b0;
			if (pkts_reg != 2'h0) begin
				pkts_reg <= pkts_reg - 2'h1;
			end
			if (flush) begin
				bytes_reg <= 11'h000;
			end
		end else if (arm_now & (pkts_reg != `USBIN_MAX_PKTS)) begin
			armed_reg <= 1'b1;
			pkts_reg <= pkts_reg + 2'h1;
			bytes_reg <= 11'h000;
		end else if (load) begin
			bytes_reg <= bytes_reg + 11'h001;
		end
	end

	// Configuration and size registers.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= `USBIN_RESET_VAL;
			maxp_reg <= `USBIN_RESET_VAL;
			out_max_packet_size_reg <= `USBIN_RESET_VAL;
		end else begin
			if (wr_cfg) begin
				cfg_reg <= wdata & 8'he8;
			end
			if (wr_maxp) begin
				maxp_reg <= wdata;
			end
			if (wr_out_max_packet_size) begin
				out_max_packet_size_reg <= wdata;
			end
		end
	end

	assign csr_rd = {2'b00, stall_sent_reg, stall_req_reg, 1'b0, underrun_reg,
		(pkts_reg != 2'h0), armed_reg};
	assign cfg_rd = cfg_reg;
	assign maxp_rd = maxp_reg;
	assign out_max_packet_size_rd = out_max_packet_size_reg;
endmodule
